// *** rtl/strap_pkg.sv ***
// Shared constants and carriers for the strap and status pin block
package strap_pkg;
    // Number of downstream ports
    localparam int unsigned NUM_PORTS = 2;
    // Strap value captured when reset is held (pins idle)
    localparam logic STRAP_RESET_VAL = 1'b0;
    // Serial select encodings
    localparam logic SERIAL_SEL_SMBUS = 1'b0;
    localparam logic SERIAL_SEL_I2C = 1'b1;
    // Polarity encodings
    localparam logic POL_ACTIVE_HIGH = 1'b0;
    // Gang encodings
    localparam logic GANG_PER_PORT = 1'b0;
    localparam logic GANG_GANGED = 1'b1;
    // Power switching disable encoding
    localparam logic PSW_ENABLED = 1'b0;
    // Fixed slave address bit 3
    localparam logic SLAVE_ADDR_BIT3 = 1'b1;
    // Slave address field positions
    localparam int unsigned ADDR_BIT1_POS = 1;
    localparam int unsigned ADDR_BIT2_POS = 2;
    localparam int unsigned ADDR_BIT3_POS = 3;
    // Width of the slave address nibble we own
    localparam int unsigned ADDR_W = 4;
    // Cycles of reset release before drivers enable
    localparam int unsigned DRIVE_DELAY_CYC = 1;

    // Configuration latched at reset release
    typedef struct packed {
        logic serial_mode_select;
        logic power_output_polarity;
        logic ganged;
        logic power_switching_disable;
        logic test_mode;
        logic [NUM_PORTS-1:0] charging_capability;
    } strap_cfg_s;

    // Connection status reported after reset
    typedef struct packed {
        logic superspeed_port2;
        logic superspeed_port1;
        logic upstream_highspeed;
        logic upstream_superspeed;
    } link_status_s;
endpackage

// *** rtl/sync2.sv ***
// Two-flop synchroniser for one pin level
`timescale 1ns/1ns
module sync2 (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Asynchronous level and synchronised copy
    input wire logic async_in,
    output logic sync_out
);
    logic meta_r; // First stage, read only by second

    // Two stages, reset to idle
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            meta_r <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// *** rtl/port_power.sv ***
// Power output driver for one downstream port
`timescale 1ns/1ns
module port_power (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Control
    input wire logic enable_in,
    input wire logic power_req_in,
    input wire logic active_low_in,
    // Pin drive level
    output logic level_out
);
    logic on_nxt; // Power on after enable gating

    // Power only when switching is enabled
    assign on_nxt = enable_in & power_req_in;

    // Registered level with polarity applied
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            level_out <= 1'b0;
        end else begin
            level_out <= on_nxt ^ active_low_in;
        end
    end
endmodule

// *** rtl/strap_status_pins.sv ***
// Strap capture at reset release and status drive on shared pins
`timescale 1ns/1ns
module strap_status_pins (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Serial mode strap pin, status for port 2
    input wire logic serial_mode_select_strap_in,
    output logic superspeed_status_port2_out,
    output logic superspeed_status_port2_oe_n_out,
    // Polarity strap pin, status for port 1
    input wire logic power_output_polarity_strap_in,
    output logic superspeed_status_port1_out,
    output logic superspeed_status_port1_oe_n_out,
    // Gang / address bit 2 strap pin, upstream high-speed status
    input wire logic slave_addr_bit2_strap_in,
    output logic upstream_highspeed_status_out,
    output logic upstream_highspeed_status_oe_n_out,
    // Switching / address bit 1 strap pin, upstream SuperSpeed status
    input wire logic slave_addr_bit1_strap_in,
    output logic upstream_superspeed_status_out,
    output logic upstream_superspeed_status_oe_n_out,
    // Test strap pin
    input wire logic test_strap_in,
    // Power pins, also charging capability straps
    input wire logic [strap_pkg::NUM_PORTS-1:0] charging_capability_strap_in,
    output logic [strap_pkg::NUM_PORTS-1:0] port_power_output_out,
    output logic [strap_pkg::NUM_PORTS-1:0] port_power_output_oe_n_out,
    // Overcurrent pins, active low
    input wire logic [strap_pkg::NUM_PORTS-1:0] overcurrent_input_n_in,
    // Serial data pin
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe_n_out,
    // EEPROM master side of the serial data line
    input wire logic eeprom_sda_drive_low_in,
    output logic eeprom_sda_out,
    // SMBus slave side of the serial data line
    input wire logic smbus_sda_drive_low_in,
    output logic smbus_sda_out,
    // Hub core status and power requests
    input wire strap_pkg::link_status_s link_status_in,
    input wire logic [strap_pkg::NUM_PORTS-1:0] power_request_in,
    // Captured configuration
    output strap_pkg::strap_cfg_s strap_cfg_out,
    output logic [strap_pkg::ADDR_W-1:0] slave_addr_out,
    output logic straps_valid_out,
    // Overcurrent reports
    output logic hub_overcurrent_out,
    output logic [strap_pkg::NUM_PORTS-1:0] port_overcurrent_out
);
    import strap_pkg::*;

    // Synchronised pin levels
    logic mode_s, pol_s, gang_s, psw_s, test_s;
    logic [NUM_PORTS-1:0] chg_s;
    logic [NUM_PORTS-1:0] oc_n_s;
    logic sda_s;
    // Capture control
    logic in_reset_r; // High from reset until capture done
    logic latched_r; // Straps captured, drivers may enable
    logic capture_now; // One-cycle capture strobe
    logic drive_en; // Shared pins may drive, off in reset
    strap_cfg_s cfg_r; // Captured configuration
    strap_cfg_s cfg_nxt;
    link_status_s status_r; // Registered status for pins
    // Decoded modes
    logic smbus_mode;
    logic switching_on;
    logic active_low;
    logic [NUM_PORTS-1:0] pwr_level;
    logic [NUM_PORTS-1:0] oc_event;
    logic [NUM_PORTS-1:0] port_oc_nxt;
    logic hub_oc_nxt;

    // Elaboration check for port count
    if (NUM_PORTS != 2) begin : g_bad_ports
        $error("strap_status_pins serves exactly two downstream ports");
    end

    // Synchronise every strap and pin level
    sync2 u_sync_mode (.clock_in(clock_in), .rst_in(1'b0),
        .async_in(serial_mode_select_strap_in), .sync_out(mode_s));
    sync2 u_sync_pol (.clock_in(clock_in), .rst_in(1'b0),
        .async_in(power_output_polarity_strap_in), .sync_out(pol_s));
    sync2 u_sync_gang (.clock_in(clock_in), .rst_in(1'b0),
        .async_in(slave_addr_bit2_strap_in), .sync_out(gang_s));
    sync2 u_sync_psw (.clock_in(clock_in), .rst_in(1'b0),
        .async_in(slave_addr_bit1_strap_in), .sync_out(psw_s));
    sync2 u_sync_test (.clock_in(clock_in), .rst_in(1'b0),
        .async_in(test_strap_in), .sync_out(test_s));
    sync2 u_sync_sda (.clock_in(clock_in), .rst_in(1'b0),
        .async_in(serial_data_in), .sync_out(sda_s));

    // Per-port synchronisers
    for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port_sync
        sync2 u_sync_chg (.clock_in(clock_in), .rst_in(1'b0),
            .async_in(charging_capability_strap_in[i]), .sync_out(chg_s[i]));
        sync2 u_sync_oc (.clock_in(clock_in), .rst_in(1'b0),
            .async_in(overcurrent_input_n_in[i]), .sync_out(oc_n_s[i]));
    end

    assign capture_now = in_reset_r & ~rst_in;

    // Next configuration from synchronised straps
    // strap sampling
    assign cfg_nxt = '{serial_mode_select: mode_s,
                       power_output_polarity: pol_s,
                       ganged: gang_s,
                       power_switching_disable: psw_s,
                       test_mode: test_s,
                       charging_capability: chg_s};

    // Reset tracker: capture happens once on release
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            in_reset_r <= 1'b1;
            latched_r <= 1'b0;
        end else begin
            in_reset_r <= 1'b0;
            latched_r <= latched_r | capture_now;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cfg_r <= '0;
        end else if (capture_now) begin
            cfg_r <= cfg_nxt;
        end
    end

    // Registered status for the pin drivers
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            status_r <= '0;
        end else begin
            status_r <= link_status_in;
        end
    end

    // Mode decodes
    assign smbus_mode = (cfg_r.serial_mode_select == SERIAL_SEL_SMBUS);
    assign switching_on = (cfg_r.power_switching_disable == PSW_ENABLED) & drive_en;
    assign active_low = (cfg_r.power_output_polarity != POL_ACTIVE_HIGH);

    assign superspeed_status_port2_out = status_r.superspeed_port2;
    assign superspeed_status_port1_out = status_r.superspeed_port1;
    assign upstream_highspeed_status_out = status_r.upstream_highspeed;
    assign upstream_superspeed_status_out = status_r.upstream_superspeed;
    // drive after capture, never in reset
    // Gating on reset keeps pins quiet from the first reset cycle
    assign drive_en = latched_r & ~rst_in;
    assign superspeed_status_port2_oe_n_out = ~drive_en;
    assign superspeed_status_port1_oe_n_out = ~drive_en;
    assign upstream_highspeed_status_oe_n_out = ~drive_en;
    assign upstream_superspeed_status_oe_n_out = ~drive_en;

    for (genvar i = 0; i < NUM_PORTS; i++) begin : g_power
        port_power u_power (
            .clock_in(clock_in),
            .rst_in(rst_in),
            .enable_in(switching_on),
            .power_req_in(power_request_in[i]),
            .active_low_in(active_low),
            .level_out(pwr_level[i])
        );
    end
    assign port_power_output_out = pwr_level;
    // Power pins undriven until capture and when switching is off
    assign port_power_output_oe_n_out = {NUM_PORTS{~switching_on}};

    // serial data line routing by mode, open drain
    assign serial_data_out = 1'b0;
    assign serial_data_oe_n_out = ~(drive_en &
        (smbus_mode ? smbus_sda_drive_low_in : eeprom_sda_drive_low_in));
    assign eeprom_sda_out = (latched_r & ~smbus_mode) ? sda_s : 1'b1;
    assign smbus_sda_out = (latched_r & smbus_mode) ? sda_s : 1'b1;

    assign slave_addr_out = smbus_mode ?
        {SLAVE_ADDR_BIT3, cfg_r.ganged, cfg_r.power_switching_disable, 1'b0} :
        {SLAVE_ADDR_BIT3, 3'h0};

    assign oc_event = ~oc_n_s & {NUM_PORTS{switching_on}};
    assign hub_oc_nxt = (cfg_r.ganged == GANG_GANGED) & (|oc_event);
    assign port_oc_nxt = (cfg_r.ganged == GANG_PER_PORT) ? oc_event : '0;

    // Registered overcurrent reports
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            hub_overcurrent_out <= 1'b0;
            port_overcurrent_out <= '0;
        end else begin
            hub_overcurrent_out <= hub_oc_nxt;
            port_overcurrent_out <= port_oc_nxt;
        end
    end

    assign strap_cfg_out = cfg_r;
    assign straps_valid_out = latched_r;

    // Assertions
    property p_undriven_in_reset;
        @(posedge clock_in) rst_in |-> superspeed_status_port2_oe_n_out
            && superspeed_status_port1_oe_n_out && upstream_highspeed_status_oe_n_out
            && upstream_superspeed_status_oe_n_out && serial_data_oe_n_out
            && (&port_power_output_oe_n_out);
    endproperty
    a_undriven_in_reset: assert property (p_undriven_in_reset)
        else $error("status pin driven during reset");

    property p_capture_once;
        @(posedge clock_in) disable iff (rst_in)
            latched_r && !capture_now |=> $stable(cfg_r);
    endproperty
    a_capture_once: assert property (p_capture_once)
        else $error("straps changed after capture");

    property p_drive_after_release;
        @(posedge clock_in) $fell(rst_in) |=> !superspeed_status_port1_oe_n_out
            && !upstream_highspeed_status_oe_n_out;
    endproperty
    a_drive_after_release: assert property (p_drive_after_release)
        else $error("status drivers not enabled after release");

    property p_status_follow;
        @(posedge clock_in) disable iff (rst_in)
            !rst_in |=>
            superspeed_status_port2_out == $past(link_status_in.superspeed_port2);
    endproperty
    a_status_follow: assert property (p_status_follow)
        else $error("port 2 status does not follow core");

    property p_addr_bit3;
        @(posedge clock_in) disable iff (rst_in) slave_addr_out[ADDR_BIT3_POS];
    endproperty
    a_addr_bit3: assert property (p_addr_bit3)
        else $error("address bit 3 not one");

    property p_addr_bits;
        @(posedge clock_in) disable iff (rst_in) latched_r && smbus_mode |->
            slave_addr_out[ADDR_BIT2_POS] == cfg_r.ganged
            && slave_addr_out[ADDR_BIT1_POS] == cfg_r.power_switching_disable;
    endproperty
    a_addr_bits: assert property (p_addr_bits)
        else $error("address bits differ from straps");

    property p_power_off_disabled;
        @(posedge clock_in) disable iff (rst_in)
            latched_r && cfg_r.power_switching_disable |-> &port_power_output_oe_n_out;
    endproperty
    a_power_off_disabled: assert property (p_power_off_disabled)
        else $error("power pins driven with switching disabled");

    property p_power_level;
        @(posedge clock_in) disable iff (rst_in)
            switching_on && $past(switching_on) |->
            port_power_output_out[0] == ($past(power_request_in[0]) ^ active_low);
    endproperty
    a_power_level: assert property (p_power_level)
        else $error("power output level wrong");

    property p_ganged_oc;
        @(posedge clock_in) disable iff (rst_in)
            cfg_r.ganged && switching_on && !oc_n_s[1] |=> hub_overcurrent_out
            && port_overcurrent_out == '0;
    endproperty
    a_ganged_oc: assert property (p_ganged_oc)
        else $error("ganged overcurrent not hub-wide");

    property p_port_oc;
        @(posedge clock_in) disable iff (rst_in)
            !cfg_r.ganged && switching_on && !oc_n_s[1] |=> port_overcurrent_out[1]
            && !hub_overcurrent_out;
    endproperty
    a_port_oc: assert property (p_port_oc)
        else $error("per-port overcurrent not reported on its port");

    property p_serial_idle;
        @(posedge clock_in) disable iff (rst_in)
            latched_r && smbus_mode |-> eeprom_sda_out;
    endproperty
    a_serial_idle: assert property (p_serial_idle)
        else $error("unselected serial engine sees a busy line");

    // Cover main scenarios
    c_smbus_mode: cover property (@(posedge clock_in) latched_r && smbus_mode);
    c_i2c_mode: cover property (@(posedge clock_in) latched_r && !smbus_mode);
    c_hub_oc: cover property (@(posedge clock_in) hub_overcurrent_out);
    c_port_oc: cover property (@(posedge clock_in) port_overcurrent_out[1]);
    c_active_low: cover property (@(posedge clock_in) switching_on && active_low);
endmodule

// *** sim/strap_board.sv ***
// Board model: strap resistors, status monitors and serial bus host
`timescale 1ns/1ns
module strap_board (
    // Strap levels fitted on the board
    input wire logic [6:0] strap_val_in,
    // Device drive on status and power pins
    input wire logic [5:0] drive_in,
    input wire logic [5:0] drive_oe_n_in,
    // Serial data line parties
    input wire logic host_sda_low_in,
    input wire logic sda_oe_n_in,
    // Resolved pin levels
    output logic [6:0] pin_out,
    output logic sda_out
);
    // Undriven pins settle to the strap resistor level
    assign pin_out[6] = drive_oe_n_in[5] ? strap_val_in[6] : drive_in[5];
    assign pin_out[5] = drive_oe_n_in[4] ? strap_val_in[5] : drive_in[4];
    assign pin_out[4] = drive_oe_n_in[3] ? strap_val_in[4] : drive_in[3];
    assign pin_out[3] = drive_oe_n_in[2] ? strap_val_in[3] : drive_in[2];
    assign pin_out[2] = strap_val_in[2];
    assign pin_out[1] = drive_oe_n_in[1] ? strap_val_in[1] : drive_in[1];
    assign pin_out[0] = drive_oe_n_in[0] ? strap_val_in[0] : drive_in[0];
    // Open-drain line with board pull-up
    assign sda_out = ~(host_sda_low_in | ~sda_oe_n_in);
endmodule

// *** sim/strap_status_pins_test.sv ***
// Self-checking bench for the strap and status pin block
`timescale 1ns/1ns
module strap_status_pins_test;
    import strap_pkg::*;
    // Stimulus
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic [6:0] strap_val = 7'h00;
    logic host_sda_low = 1'b0;
    logic eeprom_low = 1'b0;
    logic smbus_low = 1'b0;
    link_status_s link_status = '0;
    logic [1:0] power_req = 2'h0;
    logic [1:0] oc_n = 2'h3;
    // Pin levels and design outputs
    logic [6:0] pin;
    logic sda_pin, ss2, ss2_oe_n, ss1, ss1_oe_n, hs, hs_oe_n, us, us_oe_n;
    logic [1:0] pwr, pwr_oe_n, port_oc;
    logic sda_drv, sda_oe_n, eeprom_sda, smbus_sda, valid, hub_oc;
    strap_cfg_s cfg;
    logic [3:0] addr;
    // Strap combinations and serial expectations
    logic [6:0] combos [4] = '{7'h11, 7'h2e, 7'h5b, 7'h04};
    logic [2:0] exp_i2c [3] = '{3'h1, 3'h7, 3'h5};
    logic [2:0] exp_smb [3] = '{3'h7, 3'h2, 3'h6};
    int failures = 0;
    int num_checks = 0;

    always #4 clock_in = ~clock_in;

    strap_board u_strap_board (.strap_val_in(strap_val), .drive_in({ss2, ss1, hs, us, pwr}),
        .drive_oe_n_in({ss2_oe_n, ss1_oe_n, hs_oe_n, us_oe_n, pwr_oe_n}),
        .host_sda_low_in(host_sda_low), .sda_oe_n_in(sda_oe_n), .pin_out(pin), .sda_out(sda_pin));

    strap_status_pins u_strap_status_pins (.clock_in(clock_in), .rst_in(rst_in),
        .serial_mode_select_strap_in(pin[6]), .superspeed_status_port2_out(ss2),
        .superspeed_status_port2_oe_n_out(ss2_oe_n), .power_output_polarity_strap_in(pin[5]),
        .superspeed_status_port1_out(ss1), .superspeed_status_port1_oe_n_out(ss1_oe_n),
        .slave_addr_bit2_strap_in(pin[4]), .upstream_highspeed_status_out(hs),
        .upstream_highspeed_status_oe_n_out(hs_oe_n), .slave_addr_bit1_strap_in(pin[3]),
        .upstream_superspeed_status_out(us), .upstream_superspeed_status_oe_n_out(us_oe_n),
        .test_strap_in(pin[2]), .charging_capability_strap_in(pin[1:0]),
        .port_power_output_out(pwr), .port_power_output_oe_n_out(pwr_oe_n),
        .overcurrent_input_n_in(oc_n), .serial_data_in(sda_pin), .serial_data_out(sda_drv),
        .serial_data_oe_n_out(sda_oe_n), .eeprom_sda_drive_low_in(eeprom_low),
        .eeprom_sda_out(eeprom_sda), .smbus_sda_drive_low_in(smbus_low),
        .smbus_sda_out(smbus_sda), .link_status_in(link_status), .power_request_in(power_req),
        .strap_cfg_out(cfg), .slave_addr_out(addr), .straps_valid_out(valid),
        .hub_overcurrent_out(hub_oc), .port_overcurrent_out(port_oc));

    // Count and report one comparison
    task automatic compare(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Print counts and verdict, then stop
    task automatic results;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Reset with given straps, check capture and later strap changes
    task automatic reset_with(input logic [6:0] s);
        @(posedge clock_in);
        strap_val <= s;
        rst_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        #1;
        compare("enables in reset", 8'h3f, {ss2_oe_n, ss1_oe_n, hs_oe_n, us_oe_n, pwr_oe_n});
        compare("valid in reset", 8'h00, {7'h0, valid});
        @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        #1;
        compare("captured straps", {1'b0, s}, cfg);
        compare("straps valid", 8'h01, {7'h0, valid});
        compare("slave address", s[6] ? 8'h08 : {5'h01, s[4], s[3], 1'b0}, {4'h0, addr});
        compare("status enables", 8'h00, {ss2_oe_n, ss1_oe_n, hs_oe_n, us_oe_n});
        compare("power enables", s[3] ? 8'h03 : 8'h00, {6'h0, pwr_oe_n});
        @(posedge clock_in);
        strap_val <= ~s;
        repeat (3) @(posedge clock_in);
        #1;
        compare("straps after change", {1'b0, s}, cfg);
    endtask

    // Several strap sets, both serial modes, test strap
    task automatic scen_straps;
        for (int i = 0; i < 4; i++) begin
            reset_with(combos[i]);
        end
    endtask

    // Walking one across the four status pins
    task automatic scen_status;
        reset_with(7'h00);
        for (int i = 0; i < 4; i++) begin
            @(posedge clock_in);
            link_status <= link_status_s'(4'h1 << i);
            @(posedge clock_in);
            #1;
            compare("status pins", 8'h01 << i, {4'h0, ss2, ss1, hs, us});
        end
    endtask

    // Every request pattern under both polarities
    task automatic scen_power;
        for (int p = 0; p < 2; p++) begin
            reset_with({1'b0, p[0], 5'h00});
            for (int r = 0; r < 4; r++) begin
                @(posedge clock_in);
                power_req <= r[1:0];
                @(posedge clock_in);
                #1;
                compare("power level", {6'h0, r[1:0] ^ {2{p[0]}}}, {6'h0, pwr});
            end
        end
    endtask

    // Port 2 overcurrent in per-port and ganged modes
    task automatic scen_overcurrent;
        for (int g = 0; g < 2; g++) begin
            reset_with({2'h0, g[0], 4'h0});
            @(posedge clock_in);
            oc_n <= 2'h1;
            repeat (3) @(posedge clock_in);
            #1;
            compare("overcurrent", g ? 8'h04 : 8'h02, {5'h0, hub_oc, port_oc});
            @(posedge clock_in);
            oc_n <= 2'h3;
        end
    endtask

    // Each serial party pulls the data line in both modes
    task automatic scen_serial;
        for (int m = 0; m < 2; m++) begin
            reset_with({m[0], 6'h00});
            for (int k = 0; k < 3; k++) begin
                @(posedge clock_in);
                {host_sda_low, smbus_low, eeprom_low} <= 3'h1 << k;
                repeat (3) @(posedge clock_in);
                #1;
                compare("serial line", {5'h0, m ? exp_i2c[k] : exp_smb[k]},
                        {4'h0, sda_drv, sda_oe_n, eeprom_sda, smbus_sda});
            end
            @(posedge clock_in);
            {host_sda_low, smbus_low, eeprom_low} <= 3'h0;
        end
    endtask

    // Hang guard
    initial begin
        #400000;
        failures++;
        results();
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge clock_in);
        scen_straps();
        scen_status();
        scen_power();
        scen_overcurrent();
        scen_serial();
        results();
    end
endmodule
